//--- efbc_pkg.sv
// Constants, types and timing for the embedded flash block controller
package efbc_pkg;
    localparam int BLOCK_BITS       = 128;
    localparam int ECC_BITS         = 9;
    localparam int BLOCKS_PER_PAGE  = 8;
    localparam int PAGE_BYTES       = 128;
    localparam int PAGES_PER_SECTOR = 33;
    localparam int SECTORS          = 64;
    localparam int NUM_PAGES        = SECTORS * PAGES_PER_SECTOR;
    localparam int NUM_BLOCKS       = NUM_PAGES * BLOCKS_PER_PAGE;
    localparam int ADDR_W           = 19;
    localparam int BLK_W            = 15;
    localparam int PAGE_W           = 12;
    localparam int SEC_W            = 6;
    localparam int CNT_W            = 12;
    localparam int CLK_PERIOD_PS    = 4000;
    localparam int RANDOM_ACCESS_NS = 60;
    localparam int READAHEAD_NS     = 10;
    // Longest times: round down
    localparam int RANDOM_CYC       = (RANDOM_ACCESS_NS * 1000) / CLK_PERIOD_PS;
    localparam int READAHEAD_CYC    = (READAHEAD_NS * 1000) / CLK_PERIOD_PS;
    localparam int RC_OSC_MHZ       = 100;
    localparam int RC_PERIOD_PS     = 1000000 / RC_OSC_MHZ;
    localparam int PROG_RC_TICKS    = 100;
    // Least time: round up
    localparam int PROG_CYC         = (PROG_RC_TICKS * RC_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    typedef enum logic [1:0] {EFBC_W8 = 2'h0, EFBC_W16 = 2'h1, EFBC_W32 = 2'h2} efbc_width_e;
    typedef enum logic [1:0] {EFBC_OP_READ = 2'h0, EFBC_OP_WRITE = 2'h1, EFBC_OP_PROG = 2'h2} efbc_op_e;
    typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_READ = 2'h1, ST_LOAD = 2'h3, ST_PROG = 2'h2} efbc_state_e;

    typedef struct packed {
        logic              valid;
        efbc_op_e          op;
        efbc_width_e       width;
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wdata;
    } efbc_req_s;

    typedef struct packed {
        logic              valid;
        logic              commit;
        logic [ADDR_W-1:0] addr;
        logic [31:0]       data;
    } efbc_ser_s;

    typedef struct packed {
        logic        done;
        logic        from_ser;
        logic        err_prot;
        logic        err_dbl;
        logic [31:0] rdata;
    } efbc_rsp_s;

    typedef struct packed {
        logic [BLOCK_BITS-1:0] data;
        logic                  dbl;
    } efbc_dec_s;
endpackage : efbc_pkg

//--- efbc_ctrl.sv
// Embedded flash block controller: array, page buffer, block buffers, ECC, protection
`timescale 1ns/1ps
module efbc_ctrl #(
    parameter logic [31:0] SER_KEY = 32'h5A5A_A5A5 // Arbitrary stream key
) (
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    input  wire efbc_pkg::efbc_req_s     req,
    input  wire efbc_pkg::efbc_ser_s     ser,
    input  wire logic                    readahead_en,
    input  wire logic                    protect_all,
    input  wire logic [efbc_pkg::SECTORS-1:0] sector_protect,
    output efbc_pkg::efbc_rsp_s          rsp,
    output logic                         busy,
    output logic                         ser_ready
);
    import efbc_pkg::*;

    function automatic logic [ECC_BITS-1:0] ecc_gen(input logic [BLOCK_BITS-1:0] d);
        logic [7:0] pos;
        logic [7:0] c;
        pos = 8'h02;
        c   = 8'h00;
        for (int i = 0; i < BLOCK_BITS; i++)
        begin
            pos = pos + 8'h01;
            if ((pos & (pos - 8'h01)) == 8'h00)
                pos = pos + 8'h01;
            c = c ^ (pos & {8{d[i]}});
        end
        return {(^d) ^ (^c), c};
    endfunction : ecc_gen

    function automatic efbc_dec_s ecc_fix(input logic [BLOCK_BITS+ECC_BITS-1:0] w);
        logic [7:0] pos;
        logic [7:0] syn;
        logic       mis;
        efbc_dec_s  r;
        logic [ECC_BITS-1:0] chk;
        pos    = 8'h02;
        chk    = ecc_gen(w[BLOCK_BITS-1:0]);
        syn    = chk[7:0] ^ w[BLOCK_BITS+7:BLOCK_BITS];
        mis    = ^w;
        r.data = w[BLOCK_BITS-1:0];
        r.dbl  = (syn != 8'h00) && !mis;
        for (int i = 0; i < BLOCK_BITS; i++)
        begin
            pos = pos + 8'h01;
            if ((pos & (pos - 8'h01)) == 8'h00)
                pos = pos + 8'h01;
            if (mis && (syn == pos))
                r.data[i] = ~r.data[i];
        end
        return r;
    endfunction : ecc_fix

    function automatic logic [6:0] lane_shift(input logic [3:0] off, input efbc_width_e w);
        case (w)
            EFBC_W8:  lane_shift = {off, 3'h0};
            EFBC_W16: lane_shift = {off[3:1], 4'h0};
            default:  lane_shift = {off[3:2], 5'h00};
        endcase
    endfunction : lane_shift

    function automatic logic [31:0] lane_mask(input efbc_width_e w);
        case (w)
            EFBC_W8:  lane_mask = 32'h0000_00FF;
            EFBC_W16: lane_mask = 32'h0000_FFFF;
            default:  lane_mask = 32'hFFFF_FFFF;
        endcase
    endfunction : lane_mask

    function automatic logic [BLOCK_BITS-1:0] lane_merge(input logic [BLOCK_BITS-1:0] b,
                                                         input efbc_req_s q);
        logic [BLOCK_BITS-1:0] m;
        m = {96'h0, lane_mask(q.width)} << lane_shift(q.addr[3:0], q.width);
        return (b & ~m) | (({96'h0, q.wdata} << lane_shift(q.addr[3:0], q.width)) & m);
    endfunction : lane_merge

    function automatic logic prot_hit(input logic [PAGE_W-1:0] pg);
        logic [SEC_W-1:0] sec;
        sec = SEC_W'(pg / PAGE_W'(PAGES_PER_SECTOR));
        return protect_all || sector_protect[sec];
    endfunction : prot_hit

    efbc_state_e                      state_reg;
    efbc_state_e                      state_next;
    logic [CNT_W-1:0]                 cnt_reg;
    logic [BLOCK_BITS+ECC_BITS-1:0]   mem [NUM_BLOCKS];
    logic [BLOCK_BITS-1:0]            pbuf_reg [BLOCKS_PER_PAGE];
    logic [PAGE_W-1:0]                pbuf_page_reg;
    logic                             pbuf_vld_reg;
    logic [2:0]                       ldi_reg;
    logic [BLOCK_BITS-1:0]            bbuf_reg;
    logic [BLK_W-1:0]                 bbuf_idx_reg;
    logic                             bbuf_vld_reg;
    logic [BLOCK_BITS-1:0]            ahead_reg;
    logic [BLK_W-1:0]                 ahead_idx_reg;
    logic                             ahead_vld_reg;
    efbc_req_s                        pend_reg;
    logic                             pend_ser_reg;
    efbc_rsp_s                        rsp_reg;
    logic                             busy_reg;
    logic                             ser_ready_reg;
    logic                             ser_take;
    logic                             take;
    efbc_req_s                        cmd;
    logic [BLK_W-1:0]                 cmd_blk;
    logic [PAGE_W-1:0]                cmd_page;
    logic [BLK_W-1:0]                 pend_blk;
    logic [PAGE_W-1:0]                pend_page;
    logic                             bhit;
    logic                             ahit;
    logic                             rd_done;
    logic                             prog_done;
    efbc_dec_s                        rd_dec;
    efbc_dec_s                        ld_dec;
    efbc_dec_s                        nx_dec;
    logic [BLOCK_BITS-1:0]            rd_data;

    assign ser_take  = ser.valid && ser_ready_reg;
    assign take      = ser_take || (req.valid && state_reg == ST_IDLE);
    // Serial words are always 32 bits wide; XOR keystream stands in for the cipher core
    assign cmd       = ser_take ? efbc_req_s'{valid: 1'b1, op: ser.commit ? EFBC_OP_PROG : EFBC_OP_WRITE,
                                    width: EFBC_W32, addr: ser.addr, wdata: ser.data ^ SER_KEY}
                                : req;
    assign cmd_blk   = cmd.addr[ADDR_W-1:4];
    assign cmd_page  = cmd.addr[ADDR_W-1:7];
    assign pend_blk  = pend_reg.addr[ADDR_W-1:4];
    assign pend_page = pend_reg.addr[ADDR_W-1:7];
    assign bhit      = bbuf_vld_reg && bbuf_idx_reg == pend_blk;
    assign ahit      = ahead_vld_reg && ahead_idx_reg == pend_blk;
    assign rd_done   = state_reg == ST_READ && cnt_reg == '0;
    assign prog_done = state_reg == ST_PROG && cnt_reg == '0;
    assign rd_dec    = ecc_fix(mem[pend_blk]);
    assign ld_dec    = ecc_fix(mem[{pend_page, ldi_reg}]);
    // Out of range only past the last block, where the prefetch is not taken
    assign nx_dec    = ecc_fix(mem[pend_blk + BLK_W'(1)]);
    assign rd_data   = bhit ? bbuf_reg : (ahit ? ahead_reg : rd_dec.data);

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
                if (take)
                begin
                    case (cmd.op)
                        EFBC_OP_READ:  state_next = ST_READ;
                        EFBC_OP_WRITE: if (!prot_hit(cmd_page) && !(pbuf_vld_reg && pbuf_page_reg == cmd_page))
                                           state_next = ST_LOAD;
                        EFBC_OP_PROG:  if (pbuf_vld_reg && !prot_hit(pbuf_page_reg))
                                           state_next = ST_PROG;
                        default:       state_next = ST_IDLE;
                    endcase
                end
            ST_READ: if (cnt_reg == '0) state_next = ST_IDLE;
            ST_LOAD: if (ldi_reg == 3'h7) state_next = ST_IDLE;
            ST_PROG: if (cnt_reg == '0) state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    // Whole controller is private to this block; nothing is shared between instances
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg     <= ST_IDLE;
            busy_reg      <= 1'b0;
            ser_ready_reg <= 1'b0;
        end
        else
        begin
            state_reg     <= state_next;
            busy_reg      <= state_next != ST_IDLE;
            ser_ready_reg <= state_next == ST_IDLE;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cnt_reg      <= '0;
            ldi_reg      <= 3'h0;
            pend_reg     <= '0;
            pend_ser_reg <= 1'b0;
        end
        else if (state_reg == ST_IDLE && take)
        begin
            pend_reg     <= cmd;
            pend_ser_reg <= ser_take;
            ldi_reg      <= 3'h0;
            if (cmd.op == EFBC_OP_PROG)
                cnt_reg <= CNT_W'(PROG_CYC - 1);
            else if (readahead_en && ((bbuf_vld_reg && bbuf_idx_reg == cmd_blk)
                                      || (ahead_vld_reg && ahead_idx_reg == cmd_blk)))
                cnt_reg <= CNT_W'(READAHEAD_CYC - 1);
            else
                cnt_reg <= CNT_W'(RANDOM_CYC - 1);
        end
        else
        begin
            if (cnt_reg != '0)
                cnt_reg <= cnt_reg - CNT_W'(1);
            if (state_reg == ST_LOAD)
                ldi_reg <= ldi_reg + 3'h1;
        end
    end

    // Array cells are nonvolatile and carry no reset
    always_ff @(posedge clk)
    begin
        if (prog_done)
            for (int i = 0; i < BLOCKS_PER_PAGE; i++)
                mem[{pbuf_page_reg, 3'(i)}] <= {ecc_gen(pbuf_reg[i]), pbuf_reg[i]};
    end

    // Loading a new page drops unprogrammed edits to the old one
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pbuf_page_reg <= '0;
            pbuf_vld_reg  <= 1'b0;
            for (int i = 0; i < BLOCKS_PER_PAGE; i++)
                pbuf_reg[i] <= '0;
        end
        else if (state_reg == ST_IDLE && take && cmd.op == EFBC_OP_WRITE && !prot_hit(cmd_page)
                 && pbuf_vld_reg && pbuf_page_reg == cmd_page)
            pbuf_reg[cmd_blk[2:0]] <= lane_merge(pbuf_reg[cmd_blk[2:0]], cmd);
        else if (state_reg == ST_LOAD)
        begin
            pbuf_reg[ldi_reg] <= (ldi_reg == pend_blk[2:0]) ? lane_merge(ld_dec.data, pend_reg)
                                                             : ld_dec.data;
            if (ldi_reg == 3'h7)
            begin
                pbuf_page_reg <= pend_page;
                pbuf_vld_reg  <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            bbuf_reg      <= '0;
            bbuf_idx_reg  <= '0;
            bbuf_vld_reg  <= 1'b0;
            ahead_reg     <= '0;
            ahead_idx_reg <= '0;
            ahead_vld_reg <= 1'b0;
        end
        else if (prog_done)
        begin
            bbuf_vld_reg  <= 1'b0;
            ahead_vld_reg <= 1'b0;
        end
        else if (rd_done)
        begin
            bbuf_reg     <= rd_data;
            bbuf_idx_reg <= pend_blk;
            bbuf_vld_reg <= bhit || ahit || !rd_dec.dbl;
            if (readahead_en && !ahit && 32'(pend_blk) < NUM_BLOCKS - 1)
            begin
                ahead_reg     <= nx_dec.data;
                ahead_idx_reg <= pend_blk + BLK_W'(1);
                ahead_vld_reg <= !nx_dec.dbl;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            rsp_reg <= '0;
        else
        begin
            rsp_reg.done <= 1'b0;
            if (state_reg == ST_IDLE && take && state_next == ST_IDLE)
                rsp_reg <= '{done: 1'b1, from_ser: ser_take, rdata: 32'h0,
                             err_prot: cmd.op != EFBC_OP_READ
                                       && prot_hit(cmd.op == EFBC_OP_PROG ? pbuf_page_reg : cmd_page),
                             err_dbl: 1'b0};
            else if (rd_done)
                rsp_reg <= '{done: 1'b1, from_ser: pend_ser_reg, err_prot: 1'b0,
                             err_dbl: !bhit && !ahit && rd_dec.dbl,
                             rdata: 32'(rd_data >> lane_shift(pend_reg.addr[3:0], pend_reg.width))
                                    & lane_mask(pend_reg.width)};
            else if (prog_done || (state_reg == ST_LOAD && ldi_reg == 3'h7))
                rsp_reg <= '{done: 1'b1, from_ser: pend_ser_reg, err_prot: 1'b0, err_dbl: 1'b0, rdata: 32'h0};
        end
    end

    assign rsp       = rsp_reg;
    assign busy      = busy_reg;
    assign ser_ready = ser_ready_reg;

    a_prot_reject: assert property (@(posedge clk) disable iff (!reset_n)
        take && cmd.op == EFBC_OP_WRITE && prot_hit(cmd_page) |=> rsp_reg.done && rsp_reg.err_prot)
        else $error("protected write not rejected");
    a_random_latency: assert property (@(posedge clk) disable iff (!reset_n)
        take && cmd.op == EFBC_OP_READ && !readahead_en |-> ##1 !rsp_reg.done [*8] ##8 rsp_reg.done)
        else $error("random read latency wrong");
    a_ahead_latency: assert property (@(posedge clk) disable iff (!reset_n)
        take && cmd.op == EFBC_OP_READ && readahead_en && bbuf_vld_reg && bbuf_idx_reg == cmd_blk
        |-> ##2 !rsp_reg.done ##1 rsp_reg.done)
        else $error("read-ahead latency wrong");
    a_nowait_write: assert property (@(posedge clk) disable iff (!reset_n)
        take && cmd.op == EFBC_OP_WRITE && !prot_hit(cmd_page) && pbuf_vld_reg && pbuf_page_reg == cmd_page
        |=> rsp_reg.done && state_reg == ST_IDLE)
        else $error("buffered write stalled");
    a_bbuf_last: assert property (@(posedge clk) disable iff (!reset_n)
        rd_done |=> bbuf_idx_reg == $past(pend_blk) && rsp_reg.done)
        else $error("block buffer not updated");
    a_ahead_next: assert property (@(posedge clk) disable iff (!reset_n)
        rd_done && readahead_en && !ahit && !rd_dec.dbl && 32'(pend_blk) < NUM_BLOCKS - 1
        |=> ahead_idx_reg == bbuf_idx_reg + BLK_W'(1))
        else $error("next block not fetched");
    a_dbl_flag: assert property (@(posedge clk) disable iff (!reset_n)
        rd_done && !bhit && !ahit && rd_dec.dbl |=> rsp_reg.err_dbl && rsp_reg.done)
        else $error("double error not flagged");
    a_prog_time: assert property (@(posedge clk) disable iff (!reset_n)
        state_reg == ST_IDLE && take && state_next == ST_PROG
        |-> ##250 state_reg == ST_PROG ##1 state_reg == ST_IDLE && rsp_reg.done)
        else $error("program time wrong");
    a_pbuf_load: assert property (@(posedge clk) disable iff (!reset_n)
        state_reg == ST_LOAD && ldi_reg == 3'h7 |=> pbuf_vld_reg && pbuf_page_reg == $past(pend_page))
        else $error("page buffer not loaded");
endmodule : efbc_ctrl

//--- efbc_fabric_model.sv
// Fabric-side requester model that drives the parallel port of the flash controller
`timescale 1ns/1ps
module efbc_fabric_model (
    input  wire logic                clk,
    input  wire logic                busy,
    input  wire logic                ser_taken,
    input  wire efbc_pkg::efbc_rsp_s rsp,
    output efbc_pkg::efbc_req_s      req
);
    import efbc_pkg::*;

    initial req = '0;

    // One access, held until taken; returns the answer and its latency in cycles
    task automatic issue(input efbc_op_e o, input efbc_width_e w, input logic [ADDR_W-1:0] a,
                         input logic [31:0] d, output efbc_rsp_s r, output int lat);
        int n;
        @(negedge clk);
        req <= '{valid: 1'b1, op: o, width: w, addr: a, wdata: d};
        n = 0;
        // A serial word taken at the same edge wins, so keep holding then
        while ((busy !== 1'b0 || ser_taken !== 1'b0) && n < 2000)
        begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        @(negedge clk);
        // Released address and data show the inverse; op and width keep the request's values
        req <= '{valid: 1'b0, op: o, width: w, addr: ~a, wdata: ~d};
        lat = 1;
        while (rsp.done !== 1'b1 && lat < 1000)
        begin
            @(negedge clk);
            lat++;
        end
        r = rsp;
    endtask : issue
endmodule : efbc_fabric_model

//--- test_embedded_flash_block_controller.sv
// Self-checking testbench for the embedded flash block controller
`timescale 1ns/1ps
module test_embedded_flash_block_controller;
    import efbc_pkg::*;
    localparam logic [31:0] KEY = 32'hC3C3_3C3C; // Arbitrary stream key
    logic               clk;
    logic               reset_n;
    efbc_req_s          req;
    efbc_ser_s          ser;
    logic               readahead_en;
    logic               protect_all;
    logic [SECTORS-1:0] sector_protect;
    efbc_rsp_s          rsp;
    logic               busy;
    logic               ser_ready;
    logic               ser_taken;
    int                 miscompares;
    int                 cmp_count;

    assign ser_taken = ser.valid & ser_ready;
    always #2 clk = ~clk;

    efbc_ctrl #(.SER_KEY(KEY)) efbc_ctrl_inst (
        .clk            (clk),
        .reset_n        (reset_n),
        .req            (req),
        .ser            (ser),
        .readahead_en   (readahead_en),
        .protect_all    (protect_all),
        .sector_protect (sector_protect),
        .rsp            (rsp),
        .busy           (busy),
        .ser_ready      (ser_ready)
    );

    efbc_fabric_model efbc_fabric_model_inst (
        .clk       (clk),
        .busy      (busy),
        .ser_taken (ser_taken),
        .rsp       (rsp),
        .req       (req)
    );

    function automatic logic [31:0] pat(input int i);
        return {8'hA5, 8'(i), 8'h3C, ~8'(i)};
    endfunction : pat

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk32

    task automatic chk1(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk1

    // A negative expected latency skips the timing check
    task automatic op(input efbc_op_e o, input efbc_width_e w, input logic [ADDR_W-1:0] a,
                      input logic [31:0] d, input int exp_lat, output efbc_rsp_s r);
        int lat;
        efbc_fabric_model_inst.issue(o, w, a, d, r, lat);
        if (exp_lat >= 0) chk32(32'(lat), 32'(exp_lat));
        else chk1(lat < 1000, 1'b1);
        chk1(busy, 1'b0);
        chk1(ser_ready, 1'b1);
    endtask : op

    task automatic rd(input efbc_width_e w, input logic [ADDR_W-1:0] a, input logic [31:0] exp, input int exp_lat);
        efbc_rsp_s r;
        op(EFBC_OP_READ, w, a, 32'h0, exp_lat, r);
        chk32(r.rdata, exp);
        chk1(r.err_dbl, 1'b0);
        chk1(r.from_ser, 1'b0);
    endtask : rd

    task automatic ser_send(input logic cm, input logic [ADDR_W-1:0] a, input logic [31:0] plain, input int exp_lat);
        int n;
        @(negedge clk);
        ser <= '{valid: 1'b1, commit: cm, addr: a, data: plain ^ KEY};
        n = 0;
        while (ser_ready !== 1'b1 && n < 2000)
        begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        @(negedge clk);
        ser <= '{valid: 1'b0, commit: ~cm, addr: ~a, data: ~(plain ^ KEY)};
        n = 1;
        while (rsp.done !== 1'b1 && n < 1000)
        begin
            @(negedge clk);
            n++;
        end
        chk32(32'(n), 32'(exp_lat));
        chk1(rsp.from_ser, 1'b1);
        chk1(rsp.err_prot, 1'b0);
    endtask : ser_send

    // Whole blocks are written so that every block read back has valid check bits
    task automatic test_write_program_read();
        efbc_rsp_s r;
        for (int i = 0; i < 8; i++) op(EFBC_OP_WRITE, EFBC_W32, ADDR_W'(4 * i), pat(i), (i == 0) ? 9 : 1, r);
        op(EFBC_OP_WRITE, EFBC_W16, 19'h00004, 32'h0000_BEEF, 1, r);
        op(EFBC_OP_WRITE, EFBC_W8, 19'h00006, 32'h0000_005A, 1, r);
        op(EFBC_OP_WRITE, EFBC_W8, 19'h00007, 32'h0000_00C3, 1, r);
        op(EFBC_OP_PROG, EFBC_W32, 19'h00000, 32'h0, PROG_CYC + 1, r);
        chk1(r.err_prot, 1'b0);
        rd(EFBC_W32, 19'h00004, 32'hC35A_BEEF, 16);
        rd(EFBC_W16, 19'h00002, 32'h0000_A500, 16);
        rd(EFBC_W8, 19'h00001, 32'h0000_003C, 16);
        rd(EFBC_W32, 19'h0001C, pat(7), 16);
    endtask : test_write_program_read

    // Edits held in the page buffer stay invisible until programmed
    task automatic test_array_only();
        efbc_rsp_s r;
        op(EFBC_OP_WRITE, EFBC_W32, 19'h00008, 32'hDEAD_BEEF, -1, r);
        rd(EFBC_W32, 19'h00008, pat(2), 16);
    endtask : test_array_only

    task automatic test_readahead();
        @(negedge clk);
        readahead_en = 1'b1;
        rd(EFBC_W32, 19'h00000, pat(0), -1);
        repeat (20) @(negedge clk);
        rd(EFBC_W32, 19'h00010, pat(4), 3);
        rd(EFBC_W32, 19'h00014, pat(5), 3);
        readahead_en = 1'b0;
    endtask : test_readahead

    // Pages 32 and 33 sit on either side of the first sector boundary
    task automatic test_protect();
        efbc_rsp_s r;
        sector_protect[1] = 1'b1;
        op(EFBC_OP_WRITE, EFBC_W32, 19'h01080, 32'h1234_5678, 1, r);
        chk1(r.err_prot, 1'b1);
        op(EFBC_OP_WRITE, EFBC_W32, 19'h0107C, 32'h1234_5678, 9, r);
        chk1(r.err_prot, 1'b0);
        sector_protect[1] = 1'b0;
        protect_all = 1'b1;
        op(EFBC_OP_WRITE, EFBC_W32, 19'h00000, 32'hFFFF_FFFF, 1, r);
        chk1(r.err_prot, 1'b1);
        op(EFBC_OP_PROG, EFBC_W32, 19'h00000, 32'h0, 1, r);
        chk1(r.err_prot, 1'b1);
        protect_all = 1'b0;
        rd(EFBC_W32, 19'h00000, pat(0), -1);
    endtask : test_protect

    task automatic test_serial();
        for (int i = 0; i < 4; i++) ser_send(1'b0, ADDR_W'(32'h1000 + 4 * i), pat(8 + i), 1);
        ser_send(1'b1, 19'h01000, 32'h0, PROG_CYC + 1);
        rd(EFBC_W32, 19'h01004, pat(9), 16);
    endtask : test_serial

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : report_and_stop

    initial
    begin
        clk = 1'b0;
        reset_n = 1'b0;
        ser = '0;
        readahead_en = 1'b0;
        protect_all = 1'b0;
        sector_protect = '0;
        miscompares = 0;
        cmp_count = 0;
        repeat (5) @(negedge clk);
        chk1(busy, 1'b0);
        chk1(rsp.done, 1'b0);
        reset_n = 1'b1;
        @(negedge clk);
        chk1(ser_ready, 1'b1);
        test_write_program_read();
        test_array_only();
        test_readahead();
        test_protect();
        test_serial();
        report_and_stop();
    end

    // Expected run is near 700 cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        miscompares++;
        report_and_stop();
    end
endmodule : test_embedded_flash_block_controller
